// ---- shared/ssf_pkg.sv ----
// Functional notes
// - a flag other than receiver-active clears by access only after a status read with it set, then a data access.
// - long-word read of status and data clears every set receive flag other than receiver-active, armed or not, but not transmit flags.
// - a flag set after the status read stays set until a fresh read-access pair.
// - writing zeros clears nothing; a status read other than a long-word read arms every flag then set.
// - status bits 15-9 read zero; bit 8 down to bit 0 hold the nine flags.
// - transmit-empty sets on holding-to-shifter transfer and on reset.
// - a data write without a cleared transmit-empty does not start transmission.
// - transmit-complete sets when all data and preambles are shifted out.
// - receive-full sets on shifter transfer; noise, framing and parity flags set in the same cycle.
// - receiver-active sets at first start sample, clears on selected idle detection.
// - start bit checks samples 3, 5, 7; two or more high cancels it.
// - idle sets after 10 or 11 ones per eight- or nine-bit frame, not while sleeping.
// - idle cannot set again until a received frame sets receive-full or overrun, break included.
// - a word arriving while receive-full is set sets overrun and is discarded.
// - each bit sampled three times by majority; disagreement sets noise at frame end.
// - framing error sets on zero in stop position, with receive-full.
// - parity error sets on wrong parity, with receive-full.
// - receive flags other than receiver-active stay clear while the receiver is disabled.
// - any access touching the data low byte triggers clearing or transmit start.
// - while the receiver sleeps no receive flag other than receiver-active is set.
package ssf_pkg;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  localparam int BIT_TX_EMPTY = 8;
  localparam int BIT_TX_DONE = 7;
  localparam int BIT_RX_FULL = 6;
  localparam int BIT_RX_BUSY = 5;
  localparam int BIT_QUIET = 4;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_NOISE = 2;
  localparam int BIT_FRAME = 1;
  localparam int BIT_PARITY = 0;
  localparam logic [8:0] STATUS_RESET = 9'h180;
  localparam logic [8:0] RX_FLAG_MASK = 9'h05F;
  localparam logic [8:0] TX_FLAG_MASK = 9'h180;
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_TX_EN = 1;
  localparam int CTRL_SLEEP = 2;
  localparam int CTRL_QUIET_TYPE = 3;
  localparam int CTRL_NINE_BIT = 4;
  localparam int CTRL_PAR_EN = 5;
  localparam int CTRL_PAR_ODD = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0036;
  localparam logic [3:0] SAMPLES_PER_BIT = 4'hF;
  localparam logic [3:0] START_S3 = 4'h2;
  localparam logic [3:0] START_S5 = 4'h4;
  localparam logic [3:0] START_S7 = 4'h6;
  localparam logic [3:0] DATA_S8 = 4'h7;
  localparam logic [3:0] DATA_S9 = 4'h8;
  localparam logic [3:0] DATA_S10 = 4'h9;
  localparam logic [3:0] FRAME_BITS_SHORT = 4'hA;
  localparam logic [3:0] FRAME_BITS_LONG = 4'hB;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// ---- core/ssf_top.sv ----
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module ssf_top (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic avs_readdatavalid_out,
  // serial line
  input wire logic rxd_in,
  output logic txd_out
);
  import ssf_pkg::*;

  typedef enum logic [1:0] {SSF_RX_IDLE, SSF_RX_START, SSF_RX_BITS} ssf_rx_state_t;
  typedef enum logic [1:0] {SSF_TX_IDLE, SSF_TX_PRE, SSF_TX_SHIFT} ssf_tx_state_t;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic [3:0] frame_len(input logic nine);
    frame_len = nine ? FRAME_BITS_LONG : FRAME_BITS_SHORT;
  endfunction

  // register state
  logic [8:0] flags_ff, nxt_flags;
  logic [8:0] armed_ff, nxt_armed;
  logic [6:0] ctrl_ff;
  logic [15:0] baud_div_ff;
  logic [8:0] rx_hold_ff;
  logic [8:0] tx_hold_ff;
  logic tx_pending_ff;
  logic ack_ff;

  // bus decode; one wait cycle per access keeps answers registered
  wire sel_status = (avs_address_in == ADDR_STATUS);
  wire sel_data = (avs_address_in == ADDR_DATA);
  wire sel_ctrl = (avs_address_in == ADDR_CTRL);
  wire req = avs_read_in | avs_write_in;
  wire take = req & ack_ff;
  wire data_lo = avs_byteenable_in[0];
  // status read arms on any byte; long-word read spans status and data lanes
  wire status_rd = take & avs_read_in & sel_status;
  wire long_rd = status_rd & (&avs_byteenable_in);
  wire data_rd = take & avs_read_in & sel_data & data_lo;
  wire data_wr = take & avs_write_in & sel_data & data_lo;
  wire ctrl_wr = take & avs_write_in & sel_ctrl;
  wire rx_en = ctrl_ff[CTRL_RX_EN];
  wire sleep = ctrl_ff[CTRL_SLEEP];
  wire [31:0] rd_mux = sel_status ? {rx_hold_ff[7:0], 8'h00, 7'h00, flags_ff} :
                       sel_data ? {23'h000000, rx_hold_ff} :
                       sel_ctrl ? {baud_div_ff, 9'h000, ctrl_ff} : RD_UNMAPPED;

  assign avs_waitrequest_out = req & ~ack_ff;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_ff <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
      avs_readdatavalid_out <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
      avs_readdatavalid_out <= take & avs_read_in;
      // loaded in the wait cycle so read data already stands at the accepting edge
      if (req & ~ack_ff & avs_read_in) avs_readdata_out <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_ff <= CTRL_RESET;
      baud_div_ff <= BAUD_DIV_RESET;
    end else if (ctrl_wr) begin
      if (avs_byteenable_in[0]) ctrl_ff <= avs_writedata_in[6:0];
      if (avs_byteenable_in[3]) baud_div_ff <= avs_writedata_in[31:16];
    end
  end

  // 16x sample enable
  logic [15:0] div_cnt_ff;
  wire tick = (div_cnt_ff == 16'h0000);
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) div_cnt_ff <= 16'h0000;
    else div_cnt_ff <= tick ? baud_div_ff : div_cnt_ff - 16'h0001;
  end

  // receiver
  ssf_rx_state_t rx_st_ff;
  logic [3:0] rt_ff, bit_ff, ones_ff, q_rt_ff;
  logic [1:0] st_smp_ff;
  logic [2:0] smp_ff;
  logic [9:0] rx_sh_ff;
  logic noisy_ff, prev_rx_ff, quiet_ok_ff, counting_ff;
  wire nine = ctrl_ff[CTRL_NINE_BIT];
  wire [3:0] nbits = frame_len(nine);
  wire start_fail = (st_smp_ff[0] & st_smp_ff[1]) | (st_smp_ff[0] & rxd_in) | (st_smp_ff[1] & rxd_in);
  wire bit_val = maj3({rxd_in, smp_ff[1:0]});
  wire bit_noise = ~((rxd_in == smp_ff[0]) & (smp_ff[0] == smp_ff[1]));
  wire bit_end = tick & (rx_st_ff == SSF_RX_BITS) & (rt_ff == DATA_S10);
  wire frame_end = bit_end & (bit_ff == nbits - 4'h2);
  wire [9:0] frame = {bit_val, rx_sh_ff[9:1]};
  wire [8:0] word = nine ? frame[8:0] : {1'b0, frame[8:1]};
  wire stop_zero = ~bit_val;
  wire par_bad = ctrl_ff[CTRL_PAR_EN] & ((^word[7:0] ^ (nine & word[8])) ^ ctrl_ff[CTRL_PAR_ODD] ^ 1'b0 ^
                 (nine ? 1'b0 : 1'b0)) & 1'b1;
  wire rx_ok = rx_en & ~sleep;
  wire rx_xfer = frame_end & rx_ok & ~flags_ff[BIT_OVERRUN] & ~flags_ff[BIT_RX_FULL];
  wire rx_over = frame_end & rx_ok & flags_ff[BIT_RX_FULL] & ~flags_ff[BIT_OVERRUN];
  // own bit timer: the receive timer is parked while the line is idle
  wire quiet_hit = tick & counting_ff & (q_rt_ff == SAMPLES_PER_BIT) & (ones_ff == nbits - 4'h1);
  wire start_seen = tick & (rx_st_ff == SSF_RX_IDLE) & prev_rx_ff & ~rxd_in;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_st_ff <= SSF_RX_IDLE;
      rt_ff <= 4'h0;
      bit_ff <= 4'h0;
      smp_ff <= 3'h0;
      st_smp_ff <= 2'b00;
      rx_sh_ff <= 10'h000;
      noisy_ff <= 1'b0;
      prev_rx_ff <= 1'b1;
    end else if (tick) begin
      prev_rx_ff <= rxd_in;
      rt_ff <= rt_ff + 4'h1;
      smp_ff <= {smp_ff[1:0], rxd_in};
      case (rx_st_ff)
        SSF_RX_IDLE: begin
          rt_ff <= 4'h0;
          if (start_seen) rx_st_ff <= SSF_RX_START;
        end
        SSF_RX_START: begin
          if (rt_ff == START_S3) st_smp_ff[0] <= rxd_in;
          if (rt_ff == START_S5) st_smp_ff[1] <= rxd_in;
          if (rt_ff == START_S7) begin
            if (start_fail) rx_st_ff <= SSF_RX_IDLE;
            noisy_ff <= bit_noise;
          end
          if (rt_ff == SAMPLES_PER_BIT) begin
            rx_st_ff <= SSF_RX_BITS;
            bit_ff <= 4'h0;
          end
        end
        SSF_RX_BITS: begin
          if (rt_ff == DATA_S10) begin
            rx_sh_ff <= frame;
            noisy_ff <= noisy_ff | bit_noise;
            bit_ff <= bit_ff + 4'h1;
            if (frame_end) rx_st_ff <= SSF_RX_IDLE;
          end
        end
        default: rx_st_ff <= SSF_RX_IDLE;
      endcase
    end
  end

  // ones counting: short type counts any ones, long type only after a stop bit or while the receiver is idle
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ones_ff <= 4'h0;
      q_rt_ff <= 4'h0;
      counting_ff <= 1'b0;
      quiet_ok_ff <= 1'b1;
    end else begin
      if (rx_xfer | rx_over) quiet_ok_ff <= 1'b1;
      else if (quiet_hit) quiet_ok_ff <= 1'b0;
      if (tick) begin
        if (~rxd_in) begin
          counting_ff <= 1'b0;
          ones_ff <= 4'h0;
          q_rt_ff <= 4'h0;
        end else if (counting_ff) begin
          q_rt_ff <= q_rt_ff + 4'h1;
          if (quiet_hit) ones_ff <= 4'h0;
          else if (q_rt_ff == SAMPLES_PER_BIT) ones_ff <= ones_ff + 4'h1;
        end else if (frame_end | (rx_st_ff == SSF_RX_IDLE) | ~ctrl_ff[CTRL_QUIET_TYPE]) begin
          counting_ff <= 1'b1;
          q_rt_ff <= 4'h0;
        end
      end
    end
  end

  // transmitter
  ssf_tx_state_t tx_st_ff;
  logic [10:0] tx_sh_ff;
  logic [3:0] tx_bit_ff, tx_rt_ff;
  logic tx_en_d_ff;
  wire tx_load = (tx_st_ff == SSF_TX_IDLE) & tx_pending_ff & ctrl_ff[CTRL_TX_EN];
  wire tx_bit_tick = tick & (tx_rt_ff == SAMPLES_PER_BIT);
  wire tx_last = tx_bit_tick & (tx_bit_ff == nbits - 4'h1) & (tx_st_ff != SSF_TX_IDLE);
  wire tx_done = tx_last & ~tx_pending_ff;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_st_ff <= SSF_TX_IDLE;
      tx_sh_ff <= 11'h7FF;
      tx_bit_ff <= 4'h0;
      tx_rt_ff <= 4'h0;
      tx_en_d_ff <= 1'b0;
      txd_out <= 1'b1;
    end else begin
      tx_en_d_ff <= ctrl_ff[CTRL_TX_EN];
      if (tick) tx_rt_ff <= tx_rt_ff + 4'h1;
      case (tx_st_ff)
        SSF_TX_IDLE: begin
          txd_out <= 1'b1;
          tx_bit_ff <= 4'h0;
          if (ctrl_ff[CTRL_TX_EN] & ~tx_en_d_ff) tx_st_ff <= SSF_TX_PRE;
          else if (tx_load) begin
            tx_st_ff <= SSF_TX_SHIFT;
            tx_sh_ff <= nine ? {1'b1, tx_hold_ff, 1'b0} : {2'b11, tx_hold_ff[7:0], 1'b0};
          end
        end
        SSF_TX_PRE, SSF_TX_SHIFT: begin
          if (tx_bit_tick) begin
            txd_out <= (tx_st_ff == SSF_TX_PRE) | tx_sh_ff[0];
            tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
            tx_bit_ff <= tx_bit_ff + 4'h1;
            if (tx_last) tx_st_ff <= SSF_TX_IDLE;
          end
        end
        default: tx_st_ff <= SSF_TX_IDLE;
      endcase
    end
  end

  // data registers; a write while transmit-empty is not both armed and set is held back
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_hold_ff <= 9'h000;
      tx_hold_ff <= 9'h000;
      tx_pending_ff <= 1'b0;
    end else begin
      if (rx_xfer) rx_hold_ff <= word;
      if (data_wr) tx_hold_ff <= avs_writedata_in[8:0];
      if (data_wr & armed_ff[BIT_TX_EMPTY] & flags_ff[BIT_TX_EMPTY]) tx_pending_ff <= 1'b1;
      else if (tx_load) tx_pending_ff <= 1'b0;
    end
  end

  // flag set and clear; sets always win over clears
  logic [8:0] set_vec, clr_vec;
  always_comb begin
    set_vec = 9'h000;
    set_vec[BIT_TX_EMPTY] = tx_load;
    set_vec[BIT_TX_DONE] = tx_done;
    set_vec[BIT_RX_FULL] = rx_xfer;
    set_vec[BIT_NOISE] = rx_xfer & (noisy_ff | bit_noise);
    set_vec[BIT_FRAME] = rx_xfer & stop_zero;
    set_vec[BIT_PARITY] = rx_xfer & par_bad;
    set_vec[BIT_OVERRUN] = rx_over;
    set_vec[BIT_QUIET] = quiet_hit & quiet_ok_ff & rx_ok;
    set_vec[BIT_RX_BUSY] = start_seen;
    clr_vec = 9'h000;
    if (data_rd) clr_vec = armed_ff & RX_FLAG_MASK;
    if (long_rd) clr_vec = flags_ff & RX_FLAG_MASK;
    if (data_wr) clr_vec = armed_ff & TX_FLAG_MASK;
    clr_vec[BIT_RX_BUSY] = quiet_hit | (tick & (rx_st_ff == SSF_RX_START) & (rt_ff == START_S7) & start_fail);
    nxt_flags = (flags_ff & ~clr_vec) | set_vec;
    if (~rx_en) nxt_flags = nxt_flags & ~RX_FLAG_MASK;
    nxt_armed = armed_ff & ~clr_vec;
    if (status_rd & ~long_rd) nxt_armed = flags_ff;
    if (long_rd) nxt_armed = flags_ff & TX_FLAG_MASK & armed_ff;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_ff <= STATUS_RESET;
      armed_ff <= 9'h000;
    end else begin
      flags_ff <= nxt_flags;
      armed_ff <= nxt_armed;
    end
  end

  // a flag set after the arming read must not clear on the following access
  property p_new_set_survives;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (set_vec[BIT_RX_FULL] & ~armed_ff[BIT_RX_FULL]) |=> flags_ff[BIT_RX_FULL] | ~rx_en;
  endproperty
  a_new_set_survives: assert property (p_new_set_survives) else $error("new flag lost");

  property p_upper_zero;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (avs_readdatavalid_out & $past(sel_status)) |-> avs_readdata_out[15:9] == 7'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unimplemented status bits nonzero");

  property p_rx_disabled;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      ~rx_en |=> (flags_ff & RX_FLAG_MASK) == 9'h000;
  endproperty
  a_rx_disabled: assert property (p_rx_disabled) else $error("receive flag while disabled");

  property p_tx_clear_needs_arm;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      ($fell(flags_ff[BIT_TX_EMPTY])) |-> $past(data_wr) & $past(armed_ff[BIT_TX_EMPTY]);
  endproperty
  a_tx_clear_needs_arm: assert property (p_tx_clear_needs_arm) else $error("tx empty cleared unarmed");

  property p_err_with_full;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $rose(flags_ff[BIT_FRAME]) |-> $rose(flags_ff[BIT_RX_FULL]);
  endproperty
  a_err_with_full: assert property (p_err_with_full) else $error("framing flag without full");

  property p_overrun_keeps;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      rx_over |=> $stable(rx_hold_ff);
  endproperty
  a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun overwrote data");

  property p_long_keeps_tx;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      (long_rd & ~data_wr) |=> flags_ff[BIT_TX_DONE] | ~$past(flags_ff[BIT_TX_DONE]);
  endproperty
  a_long_keeps_tx: assert property (p_long_keeps_tx) else $error("long read cleared tx flag");

  sequence s_wr_unarmed;
    data_wr & ~(armed_ff[BIT_TX_EMPTY] & flags_ff[BIT_TX_EMPTY]) & ~tx_pending_ff;
  endsequence
  property p_no_start;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      s_wr_unarmed |=> ~tx_pending_ff;
  endproperty
  a_no_start: assert property (p_no_start) else $error("unarmed write started tx");
endmodule

// ---- test/ssf_remote.sv ----
`timescale 1ns/1ps
module ssf_remote #(
  parameter int BIT_CLKS = 32
) (
  // clock
  input wire logic clk_in,
  // serial line
  input wire logic txd_in,
  output logic rxd_out
);
  logic [7:0] got_byte;
  int got_cnt;
  initial begin
    rxd_out = 1'b1;
    got_byte = 8'h00;
    got_cnt = 0;
  end
  // start, eight bits lsb first, stop; line marks high between frames
  task automatic send(input logic [7:0] d, input logic stop_bit);
    logic [9:0] f;
    f = {stop_bit, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
  endtask
  // mid-bit sampling; a preamble has no start edge so it is never counted
  always @(negedge txd_in) begin
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_in);
      got_byte[i] = txd_in;
    end
    repeat (BIT_CLKS) @(posedge clk_in);
    if (txd_in === 1'b1) begin
      got_cnt++;
    end
  end
endmodule

// ---- test/test_sci_status_flags.sv ----
`timescale 1ns/1ps
module test_sci_status_flags;
  import ssf_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wait_req;
  logic rd_valid;
  logic rxd;
  logic txd;
  int errors = 0;
  int num_checks = 0;
  integer seed = 32'he43a;
  logic [31:0] q;
  logic [7:0] b0;
  logic [7:0] b1;
  always #5 ref_clk = ~ref_clk;
  ssf_top dut_u (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .avs_readdatavalid_out(rd_valid),
    .rxd_in(rxd), .txd_out(txd));
  // divisor 1 gives a 16x tick every 2 clocks, so a bit is 32 clocks
  ssf_remote #(.BIT_CLKS(32)) peer_u (.clk_in(ref_clk), .txd_in(txd), .rxd_out(rxd));
  task automatic stop_test();
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int n);
    if (n > 60) begin
      errors++;
      $display("CHECK FAILED %0t bus timeout", $time);
      stop_test();
    end
    @(posedge ref_clk);
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] e, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    be <= e;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    do begin
      tick(n++);
    end while (wait_req !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    n = 0;
    if (w) begin
      @(posedge ref_clk);
    end else begin
      q = rdata;
      @(posedge ref_clk);
      chk(rd_valid, 1'b1, "read valid");
    end
  endtask
  task automatic sts();
    bus(1'b0, ADDR_STATUS, 4'h3, 32'h0);
  endtask
  task automatic dat(input logic [3:0] e);
    bus(1'b0, ADDR_DATA, e, 32'h0);
  endtask
  task automatic bits(input int n);
    repeat (n * 32) @(posedge ref_clk);
  endtask
  task automatic rx(input logic [7:0] d, input logic s);
    peer_u.send(d, s);
    bits(1);
  endtask
  function automatic logic [7:0] par_byte(input logic [6:0] d, input logic bad);
    return {(^d) ^ bad, d};
  endfunction
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    sts();
    chk(q, {23'h0, STATUS_RESET}, "reset flags");
    bus(1'b1, ADDR_STATUS, 4'h3, 32'h0);
    sts();
    chk(q, {23'h0, STATUS_RESET}, "zero write");
    bus(1'b0, 4'hC, 4'hF, 32'h0);
    chk(q, RD_UNMAPPED, "unmapped");
    bus(1'b1, ADDR_CTRL, 4'hF, 32'h0001_0003);
    bits(12);
    b0 = $random(seed);
    b1 = $random(seed);
    sts();
    bus(1'b1, ADDR_DATA, 4'h1, {24'h0, b0});
    // second write skips the status read, so it must stay unsent
    bus(1'b1, ADDR_DATA, 4'h3, {24'h0, b1});
    bits(24);
    chk(peer_u.got_byte, b0, "tx byte");
    chk(peer_u.got_cnt, 1, "tx count");
    sts();
    chk(q[BIT_TX_DONE], 1'b1, "tx done");
    // idle flag from the quiet line after enable is armed here; clear it first
    dat(4'h1);
    for (int i = 0; i < 3; i++) begin
      b0 = $random(seed);
      rx(b0, 1'b1);
      sts();
      chk(q[8:0] & RX_FLAG_MASK, 9'h040, "rx full");
      dat(i[0] ? 4'h3 : 4'h1);
      chk(q[7:0], b0, "rx data");
      sts();
      chk(q[BIT_RX_FULL], 1'b0, "rx clear");
    end
    bits(12);
    sts();
    chk({q[BIT_QUIET], q[BIT_RX_BUSY]}, 2'b10, "quiet");
    dat(4'h1);
    bits(12);
    sts();
    chk(q[BIT_QUIET], 1'b0, "quiet again");
    b0 = $random(seed);
    fork
      peer_u.send(b0, 1'b1);
      begin
        bits(2);
        sts();
        chk(q[BIT_RX_BUSY], 1'b1, "busy");
      end
    join
    bits(1);
    dat(4'h1);
    sts();
    chk(q[BIT_RX_FULL], 1'b1, "late flag kept");
    dat(4'h1);
    b1 = $random(seed);
    rx(b0, 1'b1);
    rx(b1, 1'b1);
    sts();
    chk(q[BIT_OVERRUN], 1'b1, "overrun");
    dat(4'h1);
    chk(q[7:0], b0, "kept data");
    sts();
    chk({q[BIT_RX_FULL], q[BIT_OVERRUN]}, 2'b00, "overrun clear");
    rx(b1, 1'b0);
    bus(1'b0, ADDR_STATUS, 4'hF, 32'h0);
    chk({q[BIT_RX_FULL], q[BIT_FRAME]}, 2'b11, "framing");
    chk(q[31:24], b1, "long word data");
    sts();
    chk({q[8:6], q[BIT_FRAME]}, 4'b1100, "long word clear");
    bus(1'b1, ADDR_CTRL, 4'hF, 32'h0001_0023);
    for (int i = 0; i < 2; i++) begin
      b0 = par_byte($random(seed), i[0]);
      rx(b0, 1'b1);
      sts();
      chk({q[BIT_RX_FULL], q[BIT_PARITY]}, {1'b1, i[0]}, "parity");
      dat(4'h1);
    end
    // receiver off, then on but asleep
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, ADDR_CTRL, 4'hF, i ? 32'h0001_0007 : 32'h0001_0002);
      rx($random(seed), 1'b1);
      sts();
      chk(q[BIT_RX_FULL], 1'b0, "rx blocked");
    end
    stop_test();
  end
endmodule
